// file: verilog/spbsc_core.v
// How it works
// [R1] A read starts when read select is low on a positive rise; address stored.
// [R2] Each access is four 36-bit words over two input clock cycles.
// [R3] Normal mode: first read word after second negative rise, then every edge.
// [R4] A read request on the rise right after a read start is ignored.
// [R5] Controller starts reads at most every other positive rise.
// [R6] Deselected read port finishes its burst, then floats the outputs.
// [R7] A write starts on a positive rise; data taken on four edges from the next positive rise.
// [R8] Four words commit together; a write right after a write is ignored.
// [R9] Deselected write port finishes pending burst and ignores other inputs.
// [R10] Active-low lane selects sampled with each word; deasserted lanes untouched.
// [R11] A read after a write to that location returns the newest data.
// [R12] Both selects: read wins after idle or write; write wins after read.
// [R13] Selects sampled only on positive rises; ports do not disturb each other.
// [R14] Bypass high gives 2.5 cycle latency; low gives one cycle legacy mode.
// [R15] Valid flag is aligned with echo clocks and leads data by half cycle.
// [R16] Two complementary free-running echo clocks follow the input clock.
// [R17] Lock is reported 20 us after a stable clock with the PLL enabled.
// [R18] Halting the clocks for 30 ns or more restarts the lock wait.
// [R19] Output impedance is refreshed once every 1024 clock cycles.
// [R20] Data, selects and lane selects are registered at the clock edges.
// [R21] Each port latches the shared address itself and reaches any location.
// [R22] Lane selects map to bits 8:0, 17:9, 26:18 and 35:27.
// [R23] After reset both ports are idle and read outputs float.
// [R24] Outside a delivered burst the valid flag is low and outputs float.
`timescale 1ns/1ps
`include "spbsc_consts.vh"

module spbsc_core #(
  parameter AW = `SPBSC_ADDR_W,
  parameter LOCK_CYC = `SPBSC_PLL_LOCK_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire read_port_select_n,
  input wire write_port_select_n,
  input wire [AW-1:0] addr,
  input wire [`SPBSC_WORD_W-1:0] wr_data,
  input wire [`SPBSC_LANES-1:0] byte_lane_write_mask_n,
  input wire pll_bypass_n,
  input wire k_clock_halt,
  output reg [`SPBSC_WORD_W-1:0] rd_data,
  output reg rd_data_oe,
  output reg output_valid_flag,
  output reg echo_timing_out,
  output reg echo_timing_out_n,
  output wire pll_locked,
  output wire zq_recal_pulse
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Finds which burst word a schedule points at, counting from base.
  // Bit 2 of the result says whether any word is due this cycle.
  function [2:0] slot_of;
    input [`SPBSC_SCHED_W-1:0] sched;
    input [2:0] base;
    integer i;
    begin
      slot_of = 3'h0;
      for (i = 0; i < `SPBSC_BURST; i = i + 1) begin
        if (sched[base + i]) begin
          slot_of = {1'b1, i[1:0]};
        end
      end
    end
  endfunction

  // Replaces the lanes selected by mask with those of fresh.
  function [`SPBSC_WORD_W-1:0] lane_merge;
    input [`SPBSC_WORD_W-1:0] old;
    input [`SPBSC_WORD_W-1:0] fresh;
    input [`SPBSC_LANES-1:0] mask;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < `SPBSC_LANES; i = i + 1) begin
        if (mask[i]) begin
          lane_merge[i*`SPBSC_LANE_W +: `SPBSC_LANE_W] =
            fresh[i*`SPBSC_LANE_W +: `SPBSC_LANE_W]; // [R22]
        end
      end
    end
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg rst_meta_n;
  reg rst_sync_n;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ****************************************************************
  // Input clock phase and echo clocks
  // ****************************************************************
  // Each mclk cycle is one half of the input clock pair. Phase low marks
  // a positive rise, phase high a negative rise.
  reg k_phase;
  wire k_rise;

  assign k_rise = ~k_phase;

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      k_phase <= 1'b0;
      echo_timing_out <= 1'b0;
      echo_timing_out_n <= 1'b1;
    end else begin
      k_phase <= ~k_phase;
      echo_timing_out <= k_rise; // [R16]
      echo_timing_out_n <= ~k_rise; // [R16]
    end
  end

  // ****************************************************************
  // Port arbitration
  // ****************************************************************
  reg [1:0] prev_op;
  wire rd_start;
  wire wr_start;
  wire legacy;

  assign legacy = ~pll_bypass_n; // [R14]

  // A port whose own start happened on the previous rise is refused,
  // which also yields the read/write alternation when both are held.
  assign rd_start = k_rise & ~read_port_select_n &
    (prev_op != `SPBSC_OP_READ); // [R1] [R4] [R12] [R13]
  assign wr_start = k_rise & ~write_port_select_n &
    (prev_op != `SPBSC_OP_WRITE) & ~rd_start; // [R7] [R8] [R12] [R13]

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prev_op <= `SPBSC_OP_NONE; // [R23]
    end else if (k_rise) begin
      if (rd_start) begin
        prev_op <= `SPBSC_OP_READ;
      end else if (wr_start) begin
        prev_op <= `SPBSC_OP_WRITE;
      end else begin
        prev_op <= `SPBSC_OP_NONE;
      end
    end
  end

  // ****************************************************************
  // Write side
  // ****************************************************************
  // Bit j of the schedule is set j+1 cycles after a start. Two bursts can
  // overlap in the schedule, so the address moves to a second stage once
  // the first word is taken.
  reg [`SPBSC_SCHED_W-1:0] wr_sched;
  reg [AW-1:0] wa_pend;
  reg [AW-1:0] wa_cur;
  reg [`SPBSC_WORD_W-1:0] wbuf [0:`SPBSC_BURST-2];
  reg [`SPBSC_LANES-1:0] wmask [0:`SPBSC_BURST-2];
  reg [`SPBSC_BURST-2:0] wbuf_vld;
  wire [2:0] wr_slot;
  wire wr_take;
  wire wr_commit;
  wire [`SPBSC_LANES-1:0] lane_sel;

  assign wr_slot = slot_of(wr_sched, 3'h1); // [R2] [R7]
  assign wr_take = wr_slot[2];
  assign wr_commit = wr_take & (wr_slot[1:0] == 2'h3); // [R8]
  assign lane_sel = ~byte_lane_write_mask_n; // [R10]

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_sched <= {`SPBSC_SCHED_W{1'b0}};
      wa_pend <= {AW{1'b0}};
      wa_cur <= {AW{1'b0}};
      wbuf_vld <= 3'h0;
    end else begin
      wr_sched <= {wr_sched[`SPBSC_SCHED_W-2:0], wr_start}; // [R9]
      if (wr_start) begin
        wa_pend <= addr; // [R21]
      end
      if (wr_take && wr_slot[1:0] == 2'h0) begin
        wa_cur <= wa_pend;
      end
      if (wr_commit) begin
        wbuf_vld <= 3'h0;
      end else if (wr_take) begin
        wbuf_vld[wr_slot[1:0]] <= 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SPBSC_BURST - 1; g = g + 1) begin : hold
      always @(posedge mclk) begin
        if (wr_take && wr_slot[1:0] == g) begin
          wbuf[g] <= wr_data; // [R20]
          wmask[g] <= lane_sel; // [R10]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Array: one bank per burst word
  // ****************************************************************
  wire [AW-1:0] ra_use;
  wire [`SPBSC_WORD_W-1:0] bank_q [0:`SPBSC_BURST-1];
  reg [AW-1:0] ra_pend;
  reg [AW-1:0] ra_cur;

  generate
    for (g = 0; g < `SPBSC_BURST; g = g + 1) begin : bank
      if (g == `SPBSC_BURST - 1) begin : last
        spbsc_bank #(
          .AW(AW)
        ) u_bank (
          .mclk(mclk),
          .we(wr_commit), // [R8]
          .lane_we(lane_sel),
          .waddr(wa_cur),
          .wdata(wr_data),
          .raddr(ra_use),
          .rdata(bank_q[g])
        );
      end else begin : held
        spbsc_bank #(
          .AW(AW)
        ) u_bank (
          .mclk(mclk),
          .we(wr_commit), // [R8]
          .lane_we(wmask[g]),
          .waddr(wa_cur),
          .wdata(wbuf[g]),
          .raddr(ra_use),
          .rdata(bank_q[g])
        );
      end
    end
  endgenerate

  // ****************************************************************
  // Read side
  // ****************************************************************
  reg [`SPBSC_SCHED_W-1:0] rd_sched;
  wire [2:0] rd_base;
  wire [2:0] rd_slot;
  wire [2:0] vld_slot;
  wire rd_valid_due;
  reg [`SPBSC_WORD_W-1:0] rd_word;

  assign rd_base = legacy ? `SPBSC_RD_DATA_BASE_LEGACY :
    `SPBSC_RD_DATA_BASE_NORMAL; // [R3] [R14]
  assign rd_slot = slot_of(rd_sched, rd_base);
  assign vld_slot = slot_of(rd_sched, `SPBSC_RD_VALID_BASE_NORMAL);
  // In legacy mode the flag must lead the first word by one mclk cycle,
  // which is the start cycle itself.
  assign rd_valid_due = legacy ?
    (rd_start | (|rd_sched[2:0])) : vld_slot[2]; // [R15]
  // Legacy bursts finish before the next start can overwrite the first
  // address stage; normal bursts outlive it and need the second stage.
  assign ra_use = legacy ? ra_pend : ra_cur;

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_sched <= {`SPBSC_SCHED_W{1'b0}};
      ra_pend <= {AW{1'b0}};
      ra_cur <= {AW{1'b0}};
    end else begin
      rd_sched <= {rd_sched[`SPBSC_SCHED_W-2:0], rd_start};
      if (rd_start) begin
        ra_pend <= addr; // [R1] [R21]
      end
      if (rd_sched[`SPBSC_RD_VALID_BASE_NORMAL]) begin
        ra_cur <= ra_pend;
      end
    end
  end

  // Words of a write still waiting in the hold registers are merged over
  // the array so that a following read sees them.
  always @* begin
    rd_word = bank_q[rd_slot[1:0]];
    if (rd_slot[1:0] != 2'h3 && wbuf_vld[rd_slot[1:0]] &&
        wa_cur == ra_use) begin
      rd_word = lane_merge(rd_word, wbuf[rd_slot[1:0]],
        wmask[rd_slot[1:0]]); // [R11]
    end
  end

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data <= {`SPBSC_WORD_W{1'b0}};
      rd_data_oe <= 1'b0; // [R23]
      output_valid_flag <= 1'b0;
    end else begin
      rd_data_oe <= rd_slot[2]; // [R6] [R24]
      output_valid_flag <= rd_valid_due; // [R15] [R24]
      if (rd_slot[2]) begin
        rd_data <= rd_word; // [R2] [R3] [R20]
      end
    end
  end

  // ****************************************************************
  // Lock and impedance housekeeping
  // ****************************************************************
  spbsc_pll_track #(
    .LOCK_CYC(LOCK_CYC)
  ) u_pll (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .pll_bypass_n(pll_bypass_n),
    .k_clock_halt(k_clock_halt),
    .pll_locked(pll_locked), // [R17]
    .zq_recal_pulse(zq_recal_pulse) // [R19]
  );

endmodule // spbsc_core

// file: verilog/spbsc_consts.vh
`ifndef SPBSC_CONSTS_VH
`define SPBSC_CONSTS_VH

// ****************************************************************
// Data path geometry
// ****************************************************************
`define SPBSC_WORD_W 36
`define SPBSC_LANES 4
`define SPBSC_LANE_W 9
`define SPBSC_BURST 4
`define SPBSC_ADDR_W 10

// ****************************************************************
// Operation started on the previous positive clock rise
// ****************************************************************
`define SPBSC_OP_NONE 2'h0
`define SPBSC_OP_READ 2'h1
`define SPBSC_OP_WRITE 2'h2

// ****************************************************************
// Read pipeline offsets, in half cycles of the input clock pair
// ****************************************************************
`define SPBSC_SCHED_W 7
`define SPBSC_RD_DATA_BASE_NORMAL 3'h3
`define SPBSC_RD_DATA_BASE_LEGACY 3'h0
`define SPBSC_RD_VALID_BASE_NORMAL 3'h2

// ****************************************************************
// Timing
// ****************************************************************
`define SPBSC_CLK_PERIOD_NS 10
`define SPBSC_PLL_LOCK_NS 20000
`define SPBSC_PLL_RESET_NS 30
`define SPBSC_PLL_LOCK_CYC \
  ((`SPBSC_PLL_LOCK_NS + `SPBSC_CLK_PERIOD_NS - 1) / `SPBSC_CLK_PERIOD_NS)
`define SPBSC_PLL_RESET_CYC \
  ((`SPBSC_PLL_RESET_NS + `SPBSC_CLK_PERIOD_NS - 1) / `SPBSC_CLK_PERIOD_NS)
`define SPBSC_ZQ_PERIOD_CYC 1024

`endif

// file: verilog/spbsc_bank.v
`timescale 1ns/1ps
`include "spbsc_consts.vh"

// ****************************************************************
// One burst-word bank with per-lane write enables
// ****************************************************************
module spbsc_bank #(
  parameter AW = `SPBSC_ADDR_W
) (
  input wire mclk,
  input wire we,
  input wire [`SPBSC_LANES-1:0] lane_we,
  input wire [AW-1:0] waddr,
  input wire [`SPBSC_WORD_W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output wire [`SPBSC_WORD_W-1:0] rdata
);

  genvar g;
  generate
    for (g = 0; g < `SPBSC_LANES; g = g + 1) begin : lane
      reg [`SPBSC_LANE_W-1:0] mem [0:(1<<AW)-1];
      // A lane with its enable low keeps its stored contents.
      always @(posedge mclk) begin
        if (we && lane_we[g]) begin
          mem[waddr] <= wdata[g*`SPBSC_LANE_W +: `SPBSC_LANE_W];
        end
      end
      assign rdata[g*`SPBSC_LANE_W +: `SPBSC_LANE_W] = mem[raddr];
    end
  endgenerate

endmodule // spbsc_bank

// file: verilog/spbsc_pll_track.v
`timescale 1ns/1ps
`include "spbsc_consts.vh"

// ****************************************************************
// Lock tracking and periodic output impedance update
// ****************************************************************
module spbsc_pll_track #(
  parameter LOCK_CYC = `SPBSC_PLL_LOCK_CYC,
  parameter RESET_CYC = `SPBSC_PLL_RESET_CYC,
  parameter ZQ_CYC = `SPBSC_ZQ_PERIOD_CYC
) (
  input wire mclk,
  input wire rst_sync_n,
  input wire pll_bypass_n,
  input wire k_clock_halt,
  output reg pll_locked,
  output reg zq_recal_pulse
);

  reg [15:0] lock_cnt;
  reg [7:0] halt_cnt;
  reg [10:0] zq_cnt;

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock_cnt <= 16'h0000;
      halt_cnt <= 8'h00;
      pll_locked <= 1'b0;
    end else begin
      if (k_clock_halt) begin
        if (halt_cnt != 8'hff) begin
          halt_cnt <= halt_cnt + 8'h01;
        end
      end else begin
        halt_cnt <= 8'h00;
      end
      // A long enough halt restarts the lock wait; legacy mode never locks.
      if (!pll_bypass_n || halt_cnt >= RESET_CYC[7:0]) begin // [R18]
        lock_cnt <= 16'h0000;
        pll_locked <= 1'b0;
      end else if (!k_clock_halt) begin
        if (lock_cnt >= LOCK_CYC[15:0] - 16'h0001) begin // [R17]
          pll_locked <= 1'b1;
        end else begin
          lock_cnt <= lock_cnt + 16'h0001;
        end
      end
    end
  end

  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      zq_cnt <= 11'h000;
      zq_recal_pulse <= 1'b0;
    end else begin
      zq_recal_pulse <= 1'b0;
      if (zq_cnt == ZQ_CYC[10:0] - 11'h001) begin // [R19]
        zq_cnt <= 11'h000;
        zq_recal_pulse <= 1'b1;
      end else begin
        zq_cnt <= zq_cnt + 11'h001;
      end
    end
  end

endmodule // spbsc_pll_track

// file: bench/spbsc_core_checker.sv
`timescale 1ns/1ps
// ****
// Port-level protocol checks
// ****
module spbsc_core_checker #(
  parameter LOCK_CYC = 2000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic read_port_select_n,
  input wire logic pll_bypass_n,
  input wire logic k_clock_halt,
  input wire logic rd_data_oe,
  input wire logic output_valid_flag,
  input wire logic echo_timing_out,
  input wire logic echo_timing_out_n,
  input wire logic pll_locked,
  input wire logic zq_recal_pulse
);
  logic [2:0] sync;
  logic rd_prev;
  logic [3:0] idle;
  logic [11:0] lk;
  logic [10:0] zq;
  logic zq_seen;
  wire ok = sync[2];
  // The phase is read off the echo clock, so no second copy can drift.
  wire rd_go = ok && !echo_timing_out && !read_port_select_n && !rd_prev;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync <= 3'h0;
      rd_prev <= 1'b0;
      idle <= 4'hf;
      lk <= 12'h000;
      zq <= 11'h000;
      zq_seen <= 1'b0;
    end else begin
      sync <= {sync[1:0], 1'b1};
      if (ok && !echo_timing_out) begin
        rd_prev <= rd_go;
      end
      idle <= rd_go ? 4'h1 : (idle == 4'hf ? idle : idle + 4'h1);
      if (!pll_bypass_n || k_clock_halt) begin
        lk <= 12'h000;
      end else if (lk != 12'hfff) begin
        lk <= lk + 12'h001;
      end
      if (zq_recal_pulse) begin
        zq <= 11'h001;
        zq_seen <= 1'b1;
      end else if (zq != 11'h7ff) begin
        zq <= zq + 11'h001;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!ok);
  chk_read_timing: assert property (
    rd_go && pll_bypass_n |-> ##4 output_valid_flag ##1
    (output_valid_flag && rd_data_oe) [*3] ##1 rd_data_oe)
    else $error("normal read burst timing wrong");
  chk_legacy_timing: assert property (
    rd_go && !pll_bypass_n |-> ##1 output_valid_flag ##1
    (output_valid_flag && rd_data_oe) [*3] ##1 rd_data_oe)
    else $error("legacy read burst timing wrong");
  chk_idle_quiet: assert property (
    idle >= 4'h9 |-> !rd_data_oe && !output_valid_flag)
    else $error("read outputs active with no burst");
  chk_valid_lead: assert property (
    output_valid_flag |=> rd_data_oe)
    else $error("valid flag not followed by data");
  chk_echo_pair: assert property (
    echo_timing_out |=> !echo_timing_out && echo_timing_out_n)
    else $error("echo clocks not toggling as a pair");
  chk_lock_time: assert property (
    $rose(pll_locked) |-> lk >= LOCK_CYC - 2 && lk <= LOCK_CYC + 4)
    else $error("lock reported at wrong time");
  chk_halt_drop: assert property (
    k_clock_halt [*4] |=> !pll_locked)
    else $error("lock kept while clocks halted");
  chk_zq_period: assert property (
    zq_recal_pulse && zq_seen |-> zq == 11'h400)
    else $error("impedance update period wrong");
endmodule // spbsc_core_checker

bind spbsc_core spbsc_core_checker #(.LOCK_CYC(LOCK_CYC)) chk (
  .mclk, .rst_n, .read_port_select_n, .pll_bypass_n, .k_clock_halt,
  .rd_data_oe, .output_valid_flag, .echo_timing_out, .echo_timing_out_n,
  .pll_locked, .zq_recal_pulse);

// file: bench/spbsc_ctl_model.sv
`timescale 1ns/1ps
// ****
// Memory controller model
// ****
module spbsc_ctl_model #(
  parameter AW = 10
) (
  input wire logic mclk,
  input wire logic echo_timing_out,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [AW-1:0] addr,
  output logic [35:0] wr_data,
  output logic [3:0] byte_lane_write_mask_n,
  output logic pll_bypass_n,
  output logic k_clock_halt
);
  int wpend = 0;
  initial begin
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addr = '0;
    wr_data = 36'h000000000;
    byte_lane_write_mask_n = 4'hf;
    pll_bypass_n = 1'b1;
    k_clock_halt = 1'b0;
  end
  // One input clock cycle. Its rising half starts on an edge where the
  // echo clock still shows high.
  task automatic kcycle(input logic rps_n, input logic wps_n,
      input logic [AW-1:0] a, input logic [71:0] d, input logic [7:0] m);
    logic live;
    live = wpend > 0;
    @(posedge mclk);
    for (int n = 0; n < 3 && echo_timing_out !== 1'b1; n++) begin
      @(posedge mclk);
    end
    read_port_select_n <= rps_n;
    write_port_select_n <= wps_n;
    addr <= a;
    // Data lines with no word to carry show the inverse of the last value.
    wr_data <= live ? d[35:0] : ~wr_data;
    byte_lane_write_mask_n <= m[3:0];
    @(posedge mclk);
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= ~a;
    wr_data <= live ? d[71:36] : ~wr_data;
    byte_lane_write_mask_n <= m[7:4];
    wpend = !wps_n ? 2 : (live ? wpend - 1 : 0);
  endtask
endmodule // spbsc_ctl_model

// file: bench/spbsc_core_bench.sv
`timescale 1ns/1ps
// ****
// Self-checking bench
// ****
module spbsc_core_bench;
  logic mclk;
  logic rst_n;
  wire read_port_select_n;
  wire write_port_select_n;
  wire [9:0] addr;
  wire [35:0] wr_data;
  wire [3:0] byte_lane_write_mask_n;
  wire pll_bypass_n;
  wire k_clock_halt;
  wire [35:0] rd_data;
  wire rd_data_oe;
  wire output_valid_flag;
  wire echo_timing_out;
  wire echo_timing_out_n;
  wire pll_locked;
  wire zq_recal_pulse;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [35:0] got_q[$];
  logic [35:0] exp_q[$];
  // Mask goes to words 0 and 2, its inverse to words 1 and 3.
  logic [39:0] rows [7] = '{{4'h0, 36'hfffffffff}, {4'hf, 36'h000000000},
    {4'he, 36'h0000001ff}, {4'hd, 36'h00003fe00}, {4'hb, 36'h007fc0000},
    {4'h7, 36'hff8000000}, {4'ha, 36'h007fc01ff}};
  logic [35:0] w [4] = '{36'h123456789, 36'h0abcdef01, 36'h13579bdf0,
    36'h2468ace02};

  spbsc_ctl_model #(.AW(10)) ctl (.mclk, .echo_timing_out,
    .read_port_select_n, .write_port_select_n, .addr, .wr_data,
    .byte_lane_write_mask_n, .pll_bypass_n, .k_clock_halt);
  spbsc_core #(.AW(10), .LOCK_CYC(20)) dut (.mclk, .rst_n,
    .read_port_select_n, .write_port_select_n, .addr, .wr_data,
    .byte_lane_write_mask_n, .pll_bypass_n, .k_clock_halt, .rd_data,
    .rd_data_oe, .output_valid_flag, .echo_timing_out,
    .echo_timing_out_n, .pll_locked, .zq_recal_pulse);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rd_data_oe === 1'b1) got_q.push_back(rd_data);
  end

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up;
    n_mismatch++;
    report_and_stop;
  endtask
  task automatic cmp(input string name, input logic [35:0] e,
      input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic k(input logic r, input logic wr, input logic [9:0] a,
      input logic [71:0] d, input logic [7:0] m);
    ctl.kcycle(r, wr, a, d, m);
  endtask
  task automatic exp4(input logic [35:0] a, b, c, e);
    exp_q = {exp_q, a, b, c, e};
  endtask
  task automatic drain(input string name);
    repeat (5) k(1'b1, 1'b1, 10'h000, 72'h0, 8'hff);
    cmp({name, " count"}, 36'(exp_q.size()), 36'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      cmp(name, exp_q.pop_front(), got_q.pop_front());
    end
    exp_q.delete();
    got_q.delete();
  endtask
  task automatic wait_lock;
    for (int n = 0; pll_locked !== 1'b1; n++) begin
      if (n == 100) give_up;
      @(posedge mclk);
    end
    cmp("lock", 36'h1, {35'h0, pll_locked});
  endtask
  task automatic wait_zq(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n == 1100) give_up;
    end while (zq_recal_pulse !== 1'b1);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    give_up;
  end

  initial begin
    logic [3:0] m;
    logic [35:0] x;
    int n;
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp("oe after reset", 36'h0, {35'h0, rd_data_oe});
    cmp("valid after reset", 36'h0, {35'h0, output_valid_flag});
    for (int i = 0; i < 7; i++) begin
      {m, x} = rows[i];
      k(1'b1, 1'b0, 10'(i + 1), 72'h0, 8'h00);
      k(1'b1, 1'b1, 10'h000, 72'h0, 8'h00);
      k(1'b1, 1'b0, 10'(i + 1), 72'h0, 8'h00);
      k(1'b0, 1'b1, 10'(i + 1), {72{1'b1}}, {~m, m});
      k(1'b1, 1'b1, 10'h000, {72{1'b1}}, {~m, m});
      exp4(x, ~x, x, ~x);
      drain("lane mask");
    end
    k(1'b0, 1'b0, 10'h001, 72'h0, 8'h00);
    k(1'b0, 1'b0, 10'h020, 72'h0, 8'h00);
    k(1'b0, 1'b0, 10'h020, {w[1], w[0]}, 8'h00);
    k(1'b1, 1'b1, 10'h000, {w[3], w[2]}, 8'h00);
    exp4(36'hfffffffff, 36'h0, 36'hfffffffff, 36'h0);
    exp4(w[0], w[1], w[2], w[3]);
    drain("both selects");
    k(1'b0, 1'b1, 10'h002, 72'h0, 8'h00);
    k(1'b0, 1'b1, 10'h001, 72'h0, 8'h00);
    exp4(36'h0, 36'hfffffffff, 36'h0, 36'hfffffffff);
    drain("read after read");
    k(1'b1, 1'b0, 10'h003, 72'h0, 8'h00);
    k(1'b1, 1'b0, 10'h004, {w[1], w[0]}, 8'h00);
    k(1'b0, 1'b1, 10'h004, {w[3], w[2]}, 8'h00);
    k(1'b1, 1'b1, 10'h000, 72'h0, 8'hff);
    k(1'b0, 1'b1, 10'h003, 72'h0, 8'hff);
    x = rows[3][35:0];
    exp4(x, ~x, x, ~x);
    exp4(w[0], w[1], w[2], w[3]);
    drain("write after write");
    @(posedge mclk);
    ctl.pll_bypass_n <= 1'b0;
    k(1'b0, 1'b1, 10'h003, 72'h0, 8'hff);
    exp4(w[0], w[1], w[2], w[3]);
    drain("legacy read");
    k(1'b1, 1'b0, 10'h005, 72'h0, 8'h00);
    k(1'b0, 1'b1, 10'h005, {w[1], w[0]}, 8'h00);
    k(1'b1, 1'b1, 10'h000, {w[3], w[2]}, 8'h00);
    exp4(w[0], w[1], w[2], w[3]);
    drain("legacy forward");
    ctl.pll_bypass_n <= 1'b1;
    wait_lock();
    @(posedge mclk);
    ctl.k_clock_halt <= 1'b1;
    repeat (7) @(posedge mclk);
    cmp("lock in halt", 36'h0, {35'h0, pll_locked});
    ctl.k_clock_halt <= 1'b0;
    wait_lock();
    wait_zq(n);
    wait_zq(n);
    cmp("zq period", 36'h000000400, 36'(n));
    report_and_stop;
  end
endmodule // spbsc_core_bench
